// ### shared/cec_pkg.sv
package cec_pkg;

	localparam int CEC_CLK_HZ          = 25_000_000;
	localparam int CEC_CYCLE_MAX_MS    = 100;
	localparam int CEC_WDOG_MAX_MS     = 130;
	localparam int CEC_PWR_LOSS_MS     = 10;
	localparam int CEC_CYCLE_MAX_CYC   = CEC_CYCLE_MAX_MS * (CEC_CLK_HZ / 1000);
	localparam int CEC_WDOG_MAX_CYC    = CEC_WDOG_MAX_MS * (CEC_CLK_HZ / 1000);
	localparam int CEC_PWR_LOSS_CYC    = CEC_PWR_LOSS_MS * (CEC_CLK_HZ / 1000);
	localparam int CEC_QUEUE_DEPTH     = 8;
	localparam int CEC_QPTR_W          = 3;

	localparam logic [7:0] CEC_CODE_NONE      = 8'h00;
	localparam logic [7:0] CEC_CODE_CYCLE     = 8'hF8;
	localparam logic [7:0] CEC_CODE_VERIFY    = 8'hE7;
	localparam logic [7:0] CEC_CODE_REMOTE    = 8'hB0;
	localparam logic [7:0] CEC_CODE_DUPLEX    = 8'hD0;
	localparam logic [7:0] CEC_CODE_BATTERY   = 8'hF7;
	localparam logic [7:0] CEC_CODE_MEMORY    = 8'hF1;
	localparam logic [7:0] CEC_CODE_NO_END    = 8'hF0;
	localparam logic [7:0] CEC_CODE_IOBUS     = 8'hC0;
	localparam logic [7:0] CEC_CODE_TOO_MANY  = 8'hE1;
	localparam logic [7:0] CEC_CODE_USER_MAX  = 8'h99;
	localparam logic [7:0] CEC_CODE_CPU       = 8'hFF;
	localparam logic [7:0] CEC_CODE_POWER     = 8'hFE;

	localparam logic [31:0] CEC_ADDR_STATUS   = 32'h0000_0000;
	localparam logic [31:0] CEC_ADDR_SYSWORD  = 32'h0000_0004;
	localparam logic [31:0] CEC_ADDR_CONSOLE  = 32'h0000_0008;
	localparam logic [31:0] CEC_ADDR_WDOG     = 32'h0000_000C;
	localparam logic [31:0] CEC_ADDR_MODE     = 32'h0000_0010;

	localparam logic [1:0] CEC_MODE_PROGRAM   = 2'h0;
	localparam logic [1:0] CEC_MODE_MONITOR   = 2'h1;
	localparam logic [1:0] CEC_MODE_RUN       = 2'h2;
	localparam logic [1:0] CEC_MODE_RESET     = 2'h0;

	localparam logic [31:0] CEC_UNMAPPED_DATA = 32'h0000_0000;

	localparam int CEC_ALL_CLEAR_BIT  = 8;
	localparam int CEC_VALID_BIT      = 9;

	typedef enum logic [1:0] {
		CEC_ST_INIT_WAIT,
		CEC_ST_RUNNING,
		CEC_ST_FATAL,
		CEC_ST_POWER_DOWN
	} cec_state_type;

endpackage

// ### rtl/cec_classifier.sv
// Implementation choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
// How it works
// RULE1 - Each monitor request shows next queued message.
// RULE2 - Program mode monitor read removes that message.
// RULE3 - Run or monitor mode refuses all clearing; the code still lets user code 00 remove the oldest message in any mode.
// RULE4 - Empty queue reports the all-clear indication.
// RULE5 - Detected errors also load the failure code.
// RULE6 - Init error: no execution, power on, run off.
// RULE7 - Start input off holds init wait, no code.
// RULE8 - Remote link fault holds init wait, no code.
// RULE9 - Non-fatal: run continues, power/run/alarm lit.
// RULE10 - User failure code 01-99 raises non-fatal error.
// RULE11 - Scan over 100 ms raises F8; the code raises it only for the first overrun after reset.
// RULE12 - I/O table mismatch raises E7.
// RULE13 - Remote transmission failure raises B0-B7.
// RULE14 - Redundant system fault raises D0.
// RULE15 - Battery missing or low raises F7.
// RULE16 - Fatal: stop, outputs off, power/fatal lit.
// RULE17 - Supply loss 10 ms fatal, indicators dark.
// RULE18 - Watchdog over adjustable maximum: fatal, no code.
// RULE19 - Memory missing or parity raises fatal F1.
// RULE20 - Missing end instruction raises fatal F0.
// RULE21 - I/O bus fault raises fatal C0-C7 by rack.
// RULE22 - Too many I/O points raises fatal E1.
// RULE23 - Failure code sits in system word bits 7:0.
// RULE24 - User code 00 clears code, loads next.
// RULE25 - Severe failure instruction stops, reports its code.
// RULE26 - Fatal stays latched until restart.
// Registers: 0x00 status (RO), 0x04 system word (RO), 0x08 console message (read pops in program mode),
// 0x0C watchdog maximum in cycles (RW), 0x10 key mode (RW). Other addresses read zero, writes ignored.
module cec_classifier
	import cec_pkg::*;
#(
	parameter int WDOG_MAX_CYC   = cec_pkg::CEC_WDOG_MAX_CYC,
	parameter int CYCLE_MAX_CYC  = cec_pkg::CEC_CYCLE_MAX_CYC,
	parameter int PWR_LOSS_CYC   = cec_pkg::CEC_PWR_LOSS_CYC
) (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        resetn,
	input  wire logic        clk_en,
	// Avalon-MM slave
	input  wire logic [31:0] avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	// Asynchronous plant conditions
	input  wire logic        start_input,
	input  wire logic        remote_link_ok,
	input  wire logic        supply_ok,
	input  wire logic        battery_fault,
	input  wire logic        duplex_fault,
	// Same-clock events from the CPU core
	input  wire logic        scan_end,
	input  wire logic        io_verify_fault,
	input  wire logic        remote_tx_fault,
	input  wire logic [2:0]  remote_unit,
	input  wire logic        memory_fault,
	input  wire logic        no_end_instruction,
	input  wire logic        io_bus_fault,
	input  wire logic [2:0]  io_bus_rack,
	input  wire logic        io_points_overflow,
	input  wire logic        user_failure_instruction,
	input  wire logic        severe_failure_instruction,
	input  wire logic [7:0]  instruction_code,
	// Indicators and outputs
	output logic             power_led,
	output logic             run_led,
	output logic             alarm_led,
	output logic             fatal_led,
	output logic             run_output,
	output logic             execute_enable,
	output logic             outputs_enable,
	output logic [7:0]       failure_code
);
	import cec_pkg::*;

	typedef struct packed {
		cec_state_type st;
		logic [1:0]    s_start, s_link, s_supply, s_batt, s_dup;
		logic [CEC_QUEUE_DEPTH-1:0][7:0] queue;
		logic [CEC_QPTR_W-1:0] rd_ptr, wr_ptr, view;
		logic [CEC_QPTR_W:0]   count;
		logic [31:0]   scan_cnt;
		logic [31:0]   pwr_cnt;
		logic [31:0]   wdog_max;
		logic [1:0]    mode;
		logic          batt_seen, dup_seen, cycle_seen;
		logic [7:0]    code;
		logic          alarm;
		logic [31:0]   rdata;
		logic          ack;
		logic          led_pwr, led_run, led_alm, led_fat, run_out, exe, outs;
	} cec_regs_type;

	cec_regs_type r_q, r_d;

	logic       push;
	logic [7:0] push_code;
	logic       fatal_ev;
	logic [7:0] fatal_code;
	logic       bus_req;

	always_comb begin
		logic pop;
		logic access;
		logic [CEC_QPTR_W-1:0] slot;
		pop       = 1'b0;
		access    = 1'b0;
		slot      = '0;
		r_d       = r_q;
		push      = 1'b0;
		push_code = CEC_CODE_NONE;
		fatal_ev  = 1'b0;
		fatal_code = CEC_CODE_NONE;
		bus_req   = avs_read || avs_write;

		r_d.s_start  = {r_q.s_start[0], start_input};
		r_d.s_link   = {r_q.s_link[0], remote_link_ok};
		r_d.s_supply = {r_q.s_supply[0], supply_ok};
		r_d.s_batt   = {r_q.s_batt[0], battery_fault};
		r_d.s_dup    = {r_q.s_dup[0], duplex_fault};

		// One event per cycle is queued; a lower-priority event retries next cycle while its level stays.
		if (r_q.st == CEC_ST_RUNNING) begin
			if (scan_end) begin
				r_d.scan_cnt = 32'h0000_0000;
			end else begin
				r_d.scan_cnt = r_q.scan_cnt + 32'h0000_0001;
			end
			if (r_q.scan_cnt >= r_q.wdog_max) begin
				fatal_ev = 1'b1; // RULE18
				fatal_code = CEC_CODE_NONE;
			end else if (memory_fault) begin
				fatal_ev = 1'b1; // RULE19
				fatal_code = CEC_CODE_MEMORY;
			end else if (no_end_instruction) begin
				fatal_ev = 1'b1; // RULE20
				fatal_code = CEC_CODE_NO_END;
			end else if (io_bus_fault) begin
				fatal_ev = 1'b1; // RULE21
				fatal_code = CEC_CODE_IOBUS | {5'h00, io_bus_rack};
			end else if (io_points_overflow) begin
				fatal_ev = 1'b1; // RULE22
				fatal_code = CEC_CODE_TOO_MANY;
			end else if (severe_failure_instruction) begin
				fatal_ev = 1'b1; // RULE25
				fatal_code = instruction_code;
			end
			if (!fatal_ev) begin
				if (user_failure_instruction && instruction_code != CEC_CODE_NONE
					&& instruction_code <= CEC_CODE_USER_MAX) begin
					push = 1'b1; // RULE10
					push_code = instruction_code;
				end else if (scan_end && r_q.scan_cnt > CYCLE_MAX_CYC[31:0] && !r_q.cycle_seen) begin
					push = 1'b1; // RULE11
					push_code = CEC_CODE_CYCLE;
					r_d.cycle_seen = 1'b1;
				end else if (io_verify_fault) begin
					push = 1'b1; // RULE12
					push_code = CEC_CODE_VERIFY;
				end else if (remote_tx_fault) begin
					push = 1'b1; // RULE13
					push_code = CEC_CODE_REMOTE | {5'h00, remote_unit};
				end else if (r_q.s_dup[1] && !r_q.dup_seen) begin
					push = 1'b1; // RULE14
					push_code = CEC_CODE_DUPLEX;
					r_d.dup_seen = 1'b1;
				end else if (r_q.s_batt[1] && !r_q.batt_seen) begin
					push = 1'b1; // RULE15
					push_code = CEC_CODE_BATTERY;
					r_d.batt_seen = 1'b1;
				end
			end
		end
		if (!r_q.s_dup[1]) begin
			r_d.dup_seen = 1'b0;
		end
		if (!r_q.s_batt[1]) begin
			r_d.batt_seen = 1'b0;
		end

		// Supply loss counter runs in every state.
		if (r_q.s_supply[1]) begin
			r_d.pwr_cnt = 32'h0000_0000;
		end else if (r_q.pwr_cnt < PWR_LOSS_CYC[31:0]) begin
			r_d.pwr_cnt = r_q.pwr_cnt + 32'h0000_0001;
		end

		// Register access answers one cycle after the request, in the same cycle that waitrequest drops.
		r_d.ack = 1'b0;
		if (bus_req && !r_q.ack) begin
			access = 1'b1;
			r_d.ack = 1'b1;
		end
		if (access && avs_read) begin
			unique case (avs_address)
				CEC_ADDR_STATUS: r_d.rdata = {24'h0, r_q.count, r_q.alarm, (r_q.st == CEC_ST_FATAL),
					r_q.st == CEC_ST_RUNNING, r_q.mode == CEC_MODE_PROGRAM};
				CEC_ADDR_SYSWORD: r_d.rdata = {24'h0, r_q.code}; // RULE23
				CEC_ADDR_CONSOLE: begin
					if (r_q.count == '0) begin
						r_d.rdata = 32'h0000_0100; // RULE4
					end else if (r_q.mode == CEC_MODE_PROGRAM) begin
						// Program mode shows and removes the oldest message, so none is skipped.
						r_d.rdata = {22'h0, 1'b1, 1'b0, r_q.queue[r_q.rd_ptr]};
						pop = 1'b1; // RULE2
					end else begin
						// Browsing moves only a view offset, so the queue head stays put for later removal.
						slot = r_q.rd_ptr + r_q.view;
						r_d.rdata = {22'h0, 1'b1, 1'b0, r_q.queue[slot]}; // RULE1
						r_d.view = ({1'b0, r_q.view} + 1'b1 >= r_q.count) ? '0 : r_q.view + 1'b1; // RULE3
					end
				end
				CEC_ADDR_WDOG: r_d.rdata = r_q.wdog_max;
				CEC_ADDR_MODE: r_d.rdata = {30'h0, r_q.mode};
				default: r_d.rdata = CEC_UNMAPPED_DATA;
			endcase
		end
		if (access && avs_write && avs_byteenable[0]) begin
			if (avs_address == CEC_ADDR_WDOG) begin
				r_d.wdog_max = avs_writedata; // RULE18
			end else if (avs_address == CEC_ADDR_MODE) begin
				r_d.mode = avs_writedata[1:0];
			end
		end

		// User code 00 retires the oldest queued code and shows the one queued after it, or 00 if none.
		if (r_q.st == CEC_ST_RUNNING && !fatal_ev && user_failure_instruction
			&& instruction_code == CEC_CODE_NONE) begin
			r_d.code = (r_q.count > 1) ? r_q.queue[r_q.rd_ptr + 1'b1] : CEC_CODE_NONE; // RULE24
			if (r_q.count != '0) begin
				pop = 1'b1;
			end
		end

		if (pop) begin
			r_d.rd_ptr = r_q.rd_ptr + 1'b1;
			r_d.view = '0;
		end
		if (push && r_q.count < CEC_QUEUE_DEPTH) begin
			r_d.queue[r_q.wr_ptr] = push_code;
			r_d.wr_ptr = r_q.wr_ptr + 1'b1;
			r_d.code = push_code; // RULE5
			r_d.alarm = 1'b1;
		end
		r_d.count = r_q.count + ((push && r_q.count < CEC_QUEUE_DEPTH) ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0);
		if (r_d.count == '0) begin
			r_d.alarm = 1'b0;
		end

		unique case (r_q.st)
			CEC_ST_INIT_WAIT: begin
				if (r_q.s_start[1] && r_q.s_link[1]) begin
					r_d.st = CEC_ST_RUNNING; // RULE7 RULE8
					r_d.scan_cnt = 32'h0000_0000;
				end
			end
			CEC_ST_RUNNING: begin
				if (fatal_ev) begin
					r_d.st = CEC_ST_FATAL; // RULE16
					if (fatal_code != CEC_CODE_NONE) begin
						r_d.code = fatal_code;
					end
				end
			end
			CEC_ST_FATAL: r_d.st = CEC_ST_FATAL; // RULE26
			CEC_ST_POWER_DOWN: r_d.st = CEC_ST_POWER_DOWN;
		endcase
		if (r_q.pwr_cnt >= PWR_LOSS_CYC[31:0]) begin
			r_d.st = CEC_ST_POWER_DOWN; // RULE17
		end

		unique case (r_d.st)
			CEC_ST_INIT_WAIT: {r_d.led_pwr, r_d.led_run, r_d.led_alm, r_d.led_fat, r_d.run_out, r_d.exe, r_d.outs}
				= 7'b1000000; // RULE6
			CEC_ST_RUNNING: {r_d.led_pwr, r_d.led_run, r_d.led_alm, r_d.led_fat, r_d.run_out, r_d.exe, r_d.outs}
				= {2'b11, r_d.alarm, 4'b0111}; // RULE9
			CEC_ST_FATAL: {r_d.led_pwr, r_d.led_run, r_d.led_alm, r_d.led_fat, r_d.run_out, r_d.exe, r_d.outs}
				= 7'b1001000; // RULE16
			CEC_ST_POWER_DOWN: {r_d.led_pwr, r_d.led_run, r_d.led_alm, r_d.led_fat, r_d.run_out, r_d.exe, r_d.outs}
				= 7'b0000000; // RULE17
		endcase
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			r_q <= '0;
			r_q.st <= CEC_ST_INIT_WAIT;
			r_q.wdog_max <= WDOG_MAX_CYC[31:0];
			r_q.mode <= CEC_MODE_RESET;
			r_q.pwr_cnt <= 32'h0000_0000;
		end else if (clk_en) begin
			r_q <= r_d;
		end
	end

	assign avs_readdata    = r_q.rdata;
	assign avs_waitrequest = !r_q.ack;
	assign power_led       = r_q.led_pwr;
	assign run_led         = r_q.led_run;
	assign alarm_led       = r_q.led_alm;
	assign fatal_led       = r_q.led_fat;
	assign run_output      = r_q.run_out;
	assign execute_enable  = r_q.exe;
	assign outputs_enable  = r_q.outs;
	assign failure_code    = r_q.code;

	fatal_latch_a: assert property (@(posedge core_clk) disable iff (!resetn) // RULE26
		r_q.st == CEC_ST_FATAL && clk_en && r_q.pwr_cnt < PWR_LOSS_CYC[31:0] |=> r_q.st == CEC_ST_FATAL)
		else $error("fatal state released");
	fatal_outputs_a: assert property (@(posedge core_clk) disable iff (!resetn) // RULE16
		r_q.st == CEC_ST_FATAL |-> fatal_led && power_led && !run_output && !outputs_enable)
		else $error("fatal indicators wrong");
	init_outputs_a: assert property (@(posedge core_clk) disable iff (!resetn) // RULE6
		r_q.st == CEC_ST_INIT_WAIT && $past(r_q.st) == CEC_ST_INIT_WAIT && $past(resetn) && $past(clk_en)
		|-> power_led && !run_led && !run_output)
		else $error("init indicators wrong");
	start_hold_a: assert property (@(posedge core_clk) disable iff (!resetn) // RULE7
		r_q.st == CEC_ST_INIT_WAIT && !r_q.s_start[1] && clk_en && r_q.pwr_cnt < PWR_LOSS_CYC[31:0]
		|=> r_q.st == CEC_ST_INIT_WAIT)
		else $error("left init wait without start");
	run_outputs_a: assert property (@(posedge core_clk) disable iff (!resetn) // RULE9
		r_q.st == CEC_ST_RUNNING && $past(r_q.st) == CEC_ST_RUNNING |-> run_led && run_output && !fatal_led)
		else $error("running indicators wrong");
	keep_queue_a: assert property (@(posedge core_clk) disable iff (!resetn) // RULE3
		r_q.mode != CEC_MODE_PROGRAM && !user_failure_instruction && clk_en |=> r_q.count >= $past(r_q.count))
		else $error("message lost outside program mode");
	all_clear_a: assert property (@(posedge core_clk) disable iff (!resetn) // RULE4
		avs_read && !r_q.ack && avs_address == CEC_ADDR_CONSOLE && r_q.count == '0 && clk_en
		|=> avs_readdata == 32'h0000_0100)
		else $error("all-clear missing");
	power_dark_a: assert property (@(posedge core_clk) disable iff (!resetn) // RULE17
		r_q.st == CEC_ST_POWER_DOWN |-> !power_led && !fatal_led && !run_led)
		else $error("indicators lit after supply loss");
endmodule

// ### tb/cec_console.sv
`timescale 1ns/1ps
// Console model: one Avalon-MM transfer per request, held until waitrequest is seen low.
module cec_console (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        resetn,
	// Command side
	input  wire logic        req,
	input  wire logic        cmd_wr,
	input  wire logic [31:0] cmd_addr,
	input  wire logic [31:0] cmd_data,
	output logic             done,
	output logic [31:0]      rdata,
	// Avalon-MM master
	output logic [31:0]      avs_address,
	output logic             avs_read,
	output logic             avs_write,
	output logic [31:0]      avs_writedata,
	input  wire logic [31:0] avs_readdata,
	input  wire logic        avs_waitrequest
);
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			avs_address <= 32'h0;
			avs_writedata <= 32'h0;
			avs_read <= 1'b0;
			avs_write <= 1'b0;
			done <= 1'b0;
			rdata <= 32'h0;
		end else begin
			done <= 1'b0;
			if (!avs_read && !avs_write && req) begin
				avs_read <= !cmd_wr;
				avs_write <= cmd_wr;
				avs_address <= cmd_addr;
				avs_writedata <= cmd_data;
			end else if ((avs_read || avs_write) && !avs_waitrequest) begin
				avs_read <= 1'b0;
				avs_write <= 1'b0;
				// Released lines toggle so a stale value is never taken for a live one.
				avs_address <= ~avs_address;
				avs_writedata <= ~avs_writedata;
				rdata <= avs_readdata;
				done <= 1'b1;
			end
		end
	end
endmodule

// ### tb/cec_classifier_tb.sv
`timescale 1ns/1ps
module cec_classifier_tb;
	import cec_pkg::*;
	logic        core_clk, resetn, clk_en, req, cmd_wr, done, avs_read, avs_write, avs_waitrequest;
	logic [31:0] avs_address, avs_writedata, avs_readdata, cmd_addr, cmd_data, rdata;
	logic        start_input, remote_link_ok, supply_ok, battery_fault, duplex_fault, io_verify_fault;
	logic        remote_tx_fault, memory_fault, no_end_instruction, io_bus_fault, io_points_overflow;
	logic        user_failure_instruction, severe_failure_instruction, scan_run;
	logic        scan_end = 1'b0;
	logic [2:0]  remote_unit, io_bus_rack;
	logic [7:0]  instruction_code, failure_code, leds, u, r;
	logic        power_led, run_led, alarm_led, fatal_led, run_output, execute_enable, outputs_enable;
	logic [31:0] exp_q[$];
	logic [31:0] mask_q[$];
	logic [7:0]  msg[$];
	int          n_mismatch = 0;
	int          tests_run = 0;
	int          cyc = 0;
	int          scan_cnt = 0;
	int          seed = 32'h3a022dd0;

	assign leds = {1'b0, power_led, run_led, alarm_led, fatal_led, run_output, execute_enable, outputs_enable};
	always #20 core_clk = ~core_clk;

	cec_classifier #(.WDOG_MAX_CYC(200), .CYCLE_MAX_CYC(100), .PWR_LOSS_CYC(20)) cec_classifier_inst (
		.core_clk(core_clk), .resetn(resetn), .clk_en(clk_en), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .start_input(start_input),
		.remote_link_ok(remote_link_ok), .supply_ok(supply_ok), .battery_fault(battery_fault),
		.duplex_fault(duplex_fault), .scan_end(scan_end), .io_verify_fault(io_verify_fault),
		.remote_tx_fault(remote_tx_fault), .remote_unit(remote_unit), .memory_fault(memory_fault),
		.no_end_instruction(no_end_instruction), .io_bus_fault(io_bus_fault), .io_bus_rack(io_bus_rack),
		.io_points_overflow(io_points_overflow), .user_failure_instruction(user_failure_instruction),
		.severe_failure_instruction(severe_failure_instruction), .instruction_code(instruction_code),
		.power_led(power_led), .run_led(run_led), .alarm_led(alarm_led), .fatal_led(fatal_led),
		.run_output(run_output), .execute_enable(execute_enable), .outputs_enable(outputs_enable),
		.failure_code(failure_code));

	cec_console cec_console_inst (.core_clk(core_clk), .resetn(resetn), .req(req), .cmd_wr(cmd_wr),
		.cmd_addr(cmd_addr), .cmd_data(cmd_data), .done(done), .rdata(rdata), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

	task final_report();
		$display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task check_bus(input logic [31:0] e, input logic [31:0] m, input logic [31:0] got);
		tests_run++;
		if ((got & m) !== e) begin
			n_mismatch++;
			$display("wrong value console read expected %h seen %h", e, got & m);
		end
	endtask

	task check_pin(input string name, input logic [7:0] e, input logic [7:0] got, input logic [7:0] m);
		tests_run++;
		if ((got & m) !== e) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", name, e, got & m);
		end
	endtask

	// A stalled scan lets the watchdog and overrun logic be reached on purpose.
	always @(posedge core_clk) begin
		scan_cnt <= (scan_cnt == 39) ? 0 : scan_cnt + 1;
		scan_end <= scan_run && scan_cnt == 39;
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			n_mismatch++;
			final_report();
		end
	end

	always @(posedge core_clk) begin
		if (done === 1'b1)
			check_bus(exp_q.pop_front(), mask_q.pop_front(), rdata);
	end

	task bus(input logic wr, input logic [31:0] a, input logic [31:0] d, input logic [31:0] e, input logic [31:0] m);
		@(posedge core_clk);
		req <= 1'b1;
		cmd_wr <= wr;
		cmd_addr <= a;
		cmd_data <= d;
		exp_q.push_back(e);
		mask_q.push_back(m);
		@(posedge core_clk);
		req <= 1'b0;
		do @(posedge core_clk); while (done !== 1'b1);
	endtask

	task fire(input int k, input logic [7:0] a);
		@(posedge core_clk);
		case (k)
			0: begin
				user_failure_instruction <= 1'b1;
				instruction_code <= a;
			end
			1: io_verify_fault <= 1'b1;
			2: begin
				remote_tx_fault <= 1'b1;
				remote_unit <= a[2:0];
			end
			3: battery_fault <= 1'b1;
			4: duplex_fault <= 1'b1;
			6: begin
				severe_failure_instruction <= 1'b1;
				instruction_code <= a;
			end
			7: memory_fault <= 1'b1;
			default: begin
				io_bus_fault <= 1'b1;
				io_bus_rack <= a[2:0];
			end
		endcase
		@(posedge core_clk);
		{user_failure_instruction, io_verify_fault, remote_tx_fault, io_bus_fault} <= 4'h0;
		{severe_failure_instruction, memory_fault} <= 2'h0;
		repeat (6) @(posedge core_clk);
	endtask

	task restart(input logic st, input logic lk);
		@(posedge core_clk);
		resetn <= 1'b0;
		start_input <= st;
		remote_link_ok <= lk;
		supply_ok <= 1'b1;
		{battery_fault, duplex_fault, scan_run} <= 3'h1;
		repeat (8) @(posedge core_clk);
		resetn <= 1'b1;
		repeat (8) @(posedge core_clk);
	endtask

	initial begin
		core_clk = 1'b0;
		resetn = 1'b0;
		clk_en = 1'b1;
		{req, cmd_wr, start_input, remote_link_ok, supply_ok, battery_fault, duplex_fault} = 7'h0;
		{io_verify_fault, remote_tx_fault, memory_fault, no_end_instruction, io_bus_fault} = 5'h0;
		{io_points_overflow, user_failure_instruction, severe_failure_instruction, scan_run} = 4'h0;
		{cmd_addr, cmd_data, remote_unit, io_bus_rack, instruction_code} = 78'h0;
		restart(1'b0, 1'b1);
		check_pin("init leds", 8'h40, leds, 8'h7F);
		check_pin("init code", 8'h00, failure_code, 8'hFF);
		restart(1'b1, 1'b0);
		check_pin("link leds", 8'h40, leds, 8'h7F);
		check_pin("link code", 8'h00, failure_code, 8'hFF);
		restart(1'b1, 1'b1);
		check_pin("run leds", 8'h67, leds, 8'h7F);
		r = $random(seed);
		u = {4'(r % 8'h0A), 4'(r[3:0] % 4'h9 + 4'h1)};
		fire(0, u);
		check_pin("user code", u, failure_code, 8'hFF);
		check_pin("alarm leds", 8'h77, leds, 8'h7F);
		r = $random(seed);
		fire(1, 8'h00);
		fire(2, r);
		fire(3, 8'h00);
		fire(4, 8'h00);
		msg = '{u, CEC_CODE_VERIFY, CEC_CODE_REMOTE | {5'h00, r[2:0]}, CEC_CODE_BATTERY, CEC_CODE_DUPLEX};
		scan_run <= 1'b0;
		repeat (130) @(posedge core_clk);
		scan_run <= 1'b1;
		repeat (60) @(posedge core_clk);
		msg.push_back(CEC_CODE_CYCLE);
		bus(1'b1, CEC_ADDR_MODE, {30'h0, CEC_MODE_MONITOR}, 32'h0, 32'h0);
		foreach (msg[i]) bus(1'b0, CEC_ADDR_CONSOLE, 32'h0, 32'h200 | msg[i], 32'h3FF);
		bus(1'b0, CEC_ADDR_STATUS, 32'h0, 32'h60, 32'hF0);
		bus(1'b1, CEC_ADDR_MODE, {30'h0, CEC_MODE_PROGRAM}, 32'h0, 32'h0);
		foreach (msg[i]) bus(1'b0, CEC_ADDR_CONSOLE, 32'h0, 32'h200 | msg[i], 32'h3FF);
		bus(1'b0, CEC_ADDR_CONSOLE, 32'h0, 32'h100, 32'h3FF);
		bus(1'b0, CEC_ADDR_STATUS, 32'h0, 32'h00, 32'hF0);
		bus(1'b0, 32'h0000_0020, 32'h0, CEC_UNMAPPED_DATA, 32'hFFFF_FFFF);
		r = $random(seed);
		fire(5, r);
		check_pin("bus code", CEC_CODE_IOBUS | {5'h00, r[2:0]}, failure_code, 8'hFF);
		check_pin("fatal leds", 8'h48, leds, 8'h6F);
		fire(0, 8'h12);
		check_pin("latched leds", 8'h48, leds, 8'h6F);
		restart(1'b1, 1'b1);
		bus(1'b1, CEC_ADDR_WDOG, 32'd50, 32'h0, 32'h0);
		scan_run <= 1'b0;
		repeat (80) @(posedge core_clk);
		check_pin("wdog leds", 8'h48, leds, 8'h6F);
		check_pin("wdog code", 8'h00, failure_code, 8'hFF);
		restart(1'b1, 1'b1);
		fire(0, u);
		fire(0, 8'h00);
		check_pin("cleared code", 8'h00, failure_code, 8'hFF);
		check_pin("cleared leds", 8'h67, leds, 8'h7F);
		fire(6, r);
		check_pin("severe code", r, failure_code, 8'hFF);
		check_pin("severe leds", 8'h48, leds, 8'h6F);
		restart(1'b1, 1'b1);
		fire(7, 8'h00);
		check_pin("memory code", CEC_CODE_MEMORY, failure_code, 8'hFF);
		check_pin("memory leds", 8'h48, leds, 8'h6F);
		restart(1'b1, 1'b1);
		supply_ok <= 1'b0;
		repeat (40) @(posedge core_clk);
		check_pin("supply leds", 8'h00, leds, 8'h7F);
		final_report();
	end
endmodule
